// File: htw_port.sv
// Purpose: two-wire slave port giving a host access to the 8-bit register space
// Assumes: MCLK far faster than the serial clock; pins synchronised here
// Notes: the tuner-facing pins are muxed between GPIO and secondary bus use
// Summary of operation
// R1: Bytes on the primary data line move most significant bit first.
// R2: Strap pin levels become the slave address at reset release.
// R3: Host holds reset low at least 50 ms after supply settles.
// R4: Address bit 0 high makes us transmit, low makes us receive.
// R5: First received byte after address loads the register pointer.
// R6: Pointer is 8 bits wide, selecting one of 256 locations.
// R7: Pointer increments after every data byte read or written.
// R8: Host leaves reserved locations alone and sizes bursts accordingly.
// R9: STOP ending a matched message clears the pointer to zero.
// R10: Mismatched address means all traffic ignored until next match.
// R11: START or repeated START leaves the pointer unchanged.
// R12: Write after repeated START continues at pointer, no pointer byte.
// R13: Host ends every message with a STOP.
// R14: Read starting after a STOP returns register zero first.
// R15: Port control register can turn general pins into a secondary bus.
// R16: Scan control bit 3 set selects secondary-bus master mode.
// R17: General pin zero carries secondary clock, pin one secondary data.
// R18: Write message: address, pointer byte, data bytes, each acknowledged, STOP.
// R19: Host acks bytes to continue, not the last, then STOP.
// R20: We ack our address and received bytes, release line for host ack.
`timescale 1ns/1ns
`default_nettype none
module htw_port
   import htw_pkg::*;
#(
   parameter logic [1:0] SLAVE_ADDR_HI = htw_pkg::SLAVE_ADDR_HI_DEF
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic [htw_pkg::STRAP_BITS-1:0] ADDRESS_STRAP_PINS,
   input wire logic PRIMARY_SERIAL_CLOCK,
   input wire logic PRIMARY_SERIAL_DATA_I,
   output logic PRIMARY_SERIAL_DATA_O,
   output logic PRIMARY_SERIAL_DATA_OE,
   input wire logic GENERAL_PIN_ZERO_I,
   output logic GENERAL_PIN_ZERO_O,
   output logic GENERAL_PIN_ZERO_OE,
   input wire logic GENERAL_PIN_ONE_I,
   output logic GENERAL_PIN_ONE_O,
   output logic GENERAL_PIN_ONE_OE,
   input wire logic TUNER_CLOCK_DRIVE_LOW,
   input wire logic TUNER_DATA_DRIVE_LOW,
   output logic SECONDARY_SERIAL_CLOCK_LEVEL,
   output logic SECONDARY_SERIAL_DATA_LEVEL,
   output logic MASTER_MODE,
   output logic [7:0] SCAN_CONTROL,
   output logic [7:0] REGISTER_POINTER,
   output var htw_pkg::htw_reg_req_s REG_REQ,
   input wire logic [7:0] REG_RDATA
);
   import htw_pkg::*;

   localparam int SYNC_W = $bits(htw_lines_s) + STRAP_BITS;

   logic [1:0] rst_pipe_q;
   logic rst_n;
   logic [SYNC_W-1:0] sync_out;
   htw_lines_s lines;
   htw_lines_s lines_p_q;
   logic [STRAP_BITS-1:0] strap_s;
   logic [STRAP_BITS-1:0] strap_q;
   logic captured_q;
   logic scl_rise, scl_fall, start_c, stop_c;
   htw_state_e state_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_shift_q;
   logic rw_q;
   logic host_ack_q;
   logic sda_oe_q;
   logic sda_oe_d;
   logic [7:0] ptr_q;
   logic expect_ptr_q;
   logic matched_q;
   logic [7:0] scan_q;
   logic [7:0] gpc_q;
   logic addr_match, addr_ok, addr_bad, byte_in, tx_adv, wr_c, sec_on;
   logic [7:0] rd_byte;

   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] scan,
                                           input logic [7:0] gpc, input logic [7:0] ext);
      logic [7:0] r;
      r = ext;
      if (a == SCAN_CONTROL_OFS) begin
         r = scan;
      end else if (a == GEN_PORT_CONTROL_OFS) begin
         r = gpc;
      end
      return r;
   endfunction

   // Reset release through two flops
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_q[1];

   htw_line_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk(MCLK),
      .d_i({ADDRESS_STRAP_PINS, GENERAL_PIN_ONE_I, GENERAL_PIN_ZERO_I,
            PRIMARY_SERIAL_DATA_I, PRIMARY_SERIAL_CLOCK}),
      .q_o(sync_out)
   );
   assign lines = sync_out[$bits(htw_lines_s)-1:0];
   assign strap_s = sync_out[SYNC_W-1:$bits(htw_lines_s)];

   // Strap capture on the first clock after reset release
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         strap_q <= '0;
         captured_q <= 1'b0;
      end else if (!captured_q) begin
         strap_q <= strap_s; // [R2]
         captured_q <= 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         lines_p_q <= '1;
      end else begin
         lines_p_q <= lines;
      end
   end

   assign scl_rise = lines.scl & ~lines_p_q.scl;
   assign scl_fall = ~lines.scl & lines_p_q.scl;
   assign start_c = lines.scl & lines_p_q.scl & lines_p_q.sda & ~lines.sda;
   assign stop_c = lines.scl & lines_p_q.scl & ~lines_p_q.sda & lines.sda;

   assign addr_match = (shift_q[7:1] == {SLAVE_ADDR_HI, strap_q}) & captured_q;
   assign addr_ok = (state_q == HTW_ADDR) & scl_fall & (cnt_q == BYTE_BITS) & addr_match;
   assign addr_bad = (state_q == HTW_ADDR) & scl_fall & (cnt_q == BYTE_BITS) & ~addr_match;
   assign byte_in = (state_q == HTW_RX) & scl_fall & (cnt_q == BYTE_BITS);
   assign tx_adv = (state_q == HTW_TX_ACK) & scl_rise;
   assign wr_c = byte_in & ~expect_ptr_q;
   assign rd_byte = read_mux(ptr_q, scan_q, {lines.gp1, lines.gp0, gpc_q[5:0]}, REG_RDATA);

   // Ack slots pull low; transmit drives the top shift bit
   always_comb begin
      sda_oe_d = 1'b0;
      if (state_q == HTW_ADDR_ACK || state_q == HTW_RX_ACK) begin
         sda_oe_d = 1'b1; // [R20]
      end else if (state_q == HTW_TX) begin
         sda_oe_d = ~tx_shift_q[7]; // [R1]
      end
   end

   // Bit-level slave sequencer
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= HTW_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_shift_q <= 8'hFF;
         rw_q <= 1'b0;
         host_ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         sda_oe_q <= sda_oe_d;
         if (start_c) begin
            state_q <= HTW_ADDR;
            cnt_q <= 4'h0;
         end else if (stop_c) begin
            state_q <= HTW_IDLE;
         end else begin
            case (state_q)
               HTW_ADDR, HTW_RX: begin
                  if (scl_rise && cnt_q != BYTE_BITS) begin
                     shift_q <= {shift_q[6:0], lines.sda}; // [R1]
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == BYTE_BITS) begin
                     if (state_q == HTW_RX) begin
                        state_q <= HTW_RX_ACK; // [R18]
                     end else if (addr_match) begin
                        state_q <= HTW_ADDR_ACK;
                        rw_q <= shift_q[0]; // [R4]
                     end else begin
                        state_q <= HTW_IGNORE; // [R10]
                     end
                  end
               end
               HTW_ADDR_ACK: begin
                  if (scl_fall) begin
                     cnt_q <= 4'h0;
                     if (rw_q) begin
                        state_q <= HTW_TX; // [R4]
                        tx_shift_q <= rd_byte;
                     end else begin
                        state_q <= HTW_RX;
                     end
                  end
               end
               HTW_RX_ACK: begin
                  if (scl_fall) begin
                     state_q <= HTW_RX;
                     cnt_q <= 4'h0;
                  end
               end
               HTW_TX: begin
                  if (scl_fall) begin
                     if (cnt_q == LAST_TX_BIT) begin
                        state_q <= HTW_TX_ACK;
                     end else begin
                        tx_shift_q <= {tx_shift_q[6:0], 1'b1}; // [R1]
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end
               end
               HTW_TX_ACK: begin
                  if (scl_rise) begin
                     host_ack_q <= ~lines.sda;
                  end else if (scl_fall) begin
                     cnt_q <= 4'h0;
                     if (host_ack_q) begin
                        state_q <= HTW_TX;
                        tx_shift_q <= rd_byte;
                     end else begin
                        state_q <= HTW_IGNORE;
                     end
                  end
               end
               HTW_IDLE, HTW_IGNORE: begin
                  cnt_q <= 4'h0;
               end
               default: begin
                  state_q <= HTW_IDLE;
               end
            endcase
         end
      end
   end

   // Register pointer and its pointer-byte expectation
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= POINTER_RST;
         expect_ptr_q <= 1'b1;
         matched_q <= 1'b0;
      end else if (stop_c) begin
         matched_q <= 1'b0;
         if (matched_q) begin
            ptr_q <= POINTER_RST; // [R9]
            expect_ptr_q <= 1'b1; // [R14]
         end
      end else begin
         // Start alone touches nothing here [R11]
         if (addr_ok) begin
            matched_q <= 1'b1;
         end
         if (addr_ok && shift_q[0]) begin
            expect_ptr_q <= 1'b0; // [R12]
         end
         if (byte_in) begin
            if (expect_ptr_q) begin
               ptr_q <= shift_q; // [R5] [R6]
               expect_ptr_q <= 1'b0;
            end else begin
               ptr_q <= ptr_q + 8'h01; // [R7] [R12]
            end
         end else if (tx_adv) begin
            ptr_q <= ptr_q + 8'h01; // [R7]
         end
      end
   end

   // Local registers and write strobe toward the core
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         scan_q <= SCAN_CONTROL_RST;
         gpc_q <= GEN_PORT_CONTROL_RST;
         REG_REQ <= '0;
      end else begin
         REG_REQ.we <= wr_c;
         if (wr_c) begin
            REG_REQ.addr <= ptr_q;
            REG_REQ.wdata <= shift_q;
         end
         if (wr_c && ptr_q == SCAN_CONTROL_OFS) begin
            scan_q <= shift_q; // [R16]
         end
         if (wr_c && ptr_q == GEN_PORT_CONTROL_OFS) begin
            gpc_q <= shift_q; // [R15]
         end
      end
   end

   assign sec_on = gpc_q[GPC_SECBUS_BIT] | scan_q[SCAN_MASTER_BIT];

   // General pins: GPIO or open-drain secondary bus
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         GENERAL_PIN_ZERO_O <= 1'b0;
         GENERAL_PIN_ZERO_OE <= 1'b0;
         GENERAL_PIN_ONE_O <= 1'b0;
         GENERAL_PIN_ONE_OE <= 1'b0;
      end else if (sec_on) begin
         GENERAL_PIN_ZERO_O <= 1'b0;
         GENERAL_PIN_ZERO_OE <= TUNER_CLOCK_DRIVE_LOW; // [R17]
         GENERAL_PIN_ONE_O <= 1'b0;
         GENERAL_PIN_ONE_OE <= TUNER_DATA_DRIVE_LOW; // [R17]
      end else begin
         GENERAL_PIN_ZERO_O <= gpc_q[GPC_LEVEL0_BIT];
         GENERAL_PIN_ZERO_OE <= gpc_q[GPC_DRIVE0_BIT];
         GENERAL_PIN_ONE_O <= gpc_q[GPC_LEVEL1_BIT];
         GENERAL_PIN_ONE_OE <= gpc_q[GPC_DRIVE1_BIT];
      end
   end

   assign PRIMARY_SERIAL_DATA_O = 1'b0;
   assign PRIMARY_SERIAL_DATA_OE = sda_oe_q;
   assign SECONDARY_SERIAL_CLOCK_LEVEL = lines.gp0;
   assign SECONDARY_SERIAL_DATA_LEVEL = lines.gp1;
   assign MASTER_MODE = scan_q[SCAN_MASTER_BIT]; // [R16]
   assign SCAN_CONTROL = scan_q;
   assign REGISTER_POINTER = ptr_q;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!rst_n);

   sequence s_addr_done;
      state_q == HTW_ADDR && scl_fall && cnt_q == BYTE_BITS;
   endsequence

   sequence s_rx_done;
      state_q == HTW_RX && scl_fall && cnt_q == BYTE_BITS && !start_c && !stop_c;
   endsequence

   a_tx_msb_first: assert property ( // [R1]
      state_q == HTW_TX |=> sda_oe_q == !$past(tx_shift_q[7]))
      else $error("transmit bit not driven from top of shift");
   a_strap_latch: assert property ( // [R2]
      $rose(captured_q) |-> strap_q == $past(strap_s) ##1 $stable(strap_q))
      else $error("strap address not latched at release");
   a_dir_select: assert property ( // [R4]
      state_q == HTW_ADDR_ACK && scl_fall && !start_c && !stop_c
      |=> (state_q == HTW_TX) == $past(rw_q))
      else $error("direction bit ignored");
   a_pointer_load: assert property ( // [R5]
      s_rx_done ##0 expect_ptr_q |=> ptr_q == $past(shift_q) && !REG_REQ.we)
      else $error("pointer byte not loaded");
   a_write_inc: assert property ( // [R7]
      s_rx_done ##0 !expect_ptr_q
      |=> REG_REQ.we && REG_REQ.addr == $past(ptr_q) && ptr_q == $past(ptr_q) + 8'h01)
      else $error("write did not hit pointer and advance");
   a_stop_clear: assert property ( // [R9]
      stop_c && matched_q |=> ptr_q == 8'h00 && expect_ptr_q)
      else $error("stop did not clear pointer");
   a_ignore_miss: assert property ( // [R10]
      s_addr_done ##0 !addr_match && !start_c && !stop_c
      |=> state_q == HTW_IGNORE ##1 !sda_oe_q)
      else $error("mismatched address not ignored");
   a_start_keep: assert property ( // [R11]
      start_c |=> ptr_q == $past(ptr_q) && expect_ptr_q == $past(expect_ptr_q))
      else $error("start changed pointer");
   a_fresh_read: assert property ( // [R14]
      expect_ptr_q |-> ptr_q == 8'h00)
      else $error("pointer not zero awaiting fresh message");
   a_ack_drive: assert property ( // [R20]
      (state_q == HTW_ADDR_ACK || state_q == HTW_RX_ACK) |=> sda_oe_q)
      else $error("acknowledge not driven");
   a_host_ack_free: assert property ( // [R20]
      state_q == HTW_TX_ACK [*2] |-> !sda_oe_q)
      else $error("line held during host acknowledge");
   a_sec_pins: assert property ( // [R17]
      sec_on |=> GENERAL_PIN_ZERO_OE == $past(TUNER_CLOCK_DRIVE_LOW)
      && GENERAL_PIN_ONE_OE == $past(TUNER_DATA_DRIVE_LOW) && !GENERAL_PIN_ZERO_O)
      else $error("secondary bus not routed to general pins");
endmodule // htw_port
`default_nettype wire

// File: htw_pkg.sv
// Purpose: shared constants and types for the host two-wire register port
// Assumes: 8-bit register space behind a two-wire slave
// Notes: local registers live at scan control and general port control
`default_nettype none
package htw_pkg;
   localparam logic [7:0] SCAN_CONTROL_OFS = 8'h62;
   localparam logic [7:0] GEN_PORT_CONTROL_OFS = 8'h8C;
   localparam logic [7:0] SCAN_CONTROL_RST = 8'h00;
   localparam logic [7:0] GEN_PORT_CONTROL_RST = 8'h00;
   localparam logic [7:0] POINTER_RST = 8'h00;
   localparam logic [1:0] SLAVE_ADDR_HI_DEF = 2'h0;
   localparam int SCAN_MASTER_BIT = 3;
   localparam int GPC_LEVEL0_BIT = 0;
   localparam int GPC_LEVEL1_BIT = 1;
   localparam int GPC_DRIVE0_BIT = 2;
   localparam int GPC_DRIVE1_BIT = 3;
   localparam int GPC_SECBUS_BIT = 4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   localparam int STRAP_BITS = 5;

   typedef enum logic [2:0] {
      HTW_IDLE, HTW_ADDR, HTW_ADDR_ACK, HTW_RX, HTW_RX_ACK, HTW_TX, HTW_TX_ACK, HTW_IGNORE
   } htw_state_e;

   typedef struct packed {
      logic gp1;
      logic gp0;
      logic sda;
      logic scl;
   } htw_lines_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
   } htw_reg_req_s;
endpackage
`default_nettype wire

// File: htw_line_sync.sv
// Purpose: two-flop synchroniser for pins entering the core clock domain
// Assumes: inputs are asynchronous levels
// Notes: no reset, so strap levels are already settled at reset release
`timescale 1ns/1ns
`default_nettype none
module htw_line_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("htw_line_sync WIDTH must be positive");
   end

   always_ff @(posedge clk) begin
      meta_q <= d_i;
      q_o <= meta_q;
   end
endmodule // htw_line_sync
`default_nettype wire

// File: htw_host.sv
// Purpose: host master model driving the primary two-wire bus
// Assumes: open-drain data, pull-up modelled by the bench
// Notes: serial clock made only inside messages
`timescale 1ns/1ns
`default_nettype none
module htw_host (
   input wire logic clk,
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   localparam int PH = 25;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hw();
      repeat (PH) @(negedge clk);
   endtask
   task automatic start();
      sda_low = 1'b0;
      hw();
      scl = 1'b1;
      hw();
      sda_low = 1'b1;
      hw();
      scl = 1'b0;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      hw();
      scl = 1'b1;
      hw();
      sda_low = 1'b0;
      hw();
   endtask
   task automatic clk_bit(output logic b);
      hw();
      scl = 1'b1;
      hw();
      b = sda;
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         sda_low = !v[i];
         clk_bit(b);
      end
      sda_low = 1'b0;
      clk_bit(b);
      ack = !b;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] v);
      logic b;
      sda_low = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(b);
         v[i] = b;
      end
      sda_low = ack;
      clk_bit(b);
      sda_low = 1'b0;
   endtask
endmodule // htw_host
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the two-wire register port
// Assumes: slave address {SLAVE_ADDR_HI, strap} with strap 0F
// Notes: register writes checked from a queue by a watcher
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import htw_pkg::*;
   logic mclk, resetn, scl, sda_low, sda, sd_o, sd_oe;
   logic g0, g1, g0_o, g0_oe, g1_o, g1_oe, tck, tdt, sck_lv, sdt_lv, mm, a;
   logic [4:0] strap;
   logic [7:0] scan, ptr, rdata, p;
   logic [7:0] mem [256];
   logic [15:0] e_q;
   logic [15:0] expq [$];
   htw_reg_req_s req;
   int err_count, checked;
   assign sda = !(sda_low | (sd_oe & !sd_o));
   assign g0 = g0_oe ? g0_o : 1'b1;
   assign g1 = g1_oe ? g1_o : 1'b1;
   assign rdata = mem[ptr];
   htw_port htw_port_i (.MCLK(mclk), .RESETN(resetn), .ADDRESS_STRAP_PINS(strap),
      .PRIMARY_SERIAL_CLOCK(scl), .PRIMARY_SERIAL_DATA_I(sda), .PRIMARY_SERIAL_DATA_O(sd_o),
      .PRIMARY_SERIAL_DATA_OE(sd_oe), .GENERAL_PIN_ZERO_I(g0), .GENERAL_PIN_ZERO_O(g0_o),
      .GENERAL_PIN_ZERO_OE(g0_oe), .GENERAL_PIN_ONE_I(g1), .GENERAL_PIN_ONE_O(g1_o),
      .GENERAL_PIN_ONE_OE(g1_oe), .TUNER_CLOCK_DRIVE_LOW(tck), .TUNER_DATA_DRIVE_LOW(tdt),
      .SECONDARY_SERIAL_CLOCK_LEVEL(sck_lv), .SECONDARY_SERIAL_DATA_LEVEL(sdt_lv),
      .MASTER_MODE(mm), .SCAN_CONTROL(scan), .REGISTER_POINTER(ptr), .REG_REQ(req),
      .REG_RDATA(rdata));
   htw_host host_i (.clk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic check(string nm, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic addr(logic rw, logic [7:0] exp_ack);
      host_i.wbyte({SLAVE_ADDR_HI_DEF, 5'h0F, rw}, a);
      check("address ack", exp_ack, {7'h0, a});
   endtask
   task automatic wptr(logic [7:0] v);
      host_i.wbyte(v, a);
      check("pointer ack", 8'h01, {7'h0, a});
   endtask
   task automatic wdat(logic [7:0] v, logic [7:0] at);
      expq.push_back({at, v});
      host_i.wbyte(v, a);
      check("data ack", 8'h01, {7'h0, a});
   endtask
   task automatic rdat(logic [7:0] at, logic ack);
      logic [7:0] v;
      host_i.rbyte(ack, v);
      check("read data", mem[at], v);
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge mclk);
   endtask
   // Register write port watcher
   always @(negedge mclk) begin
      if (req.we === 1'b1) begin
         if (expq.size() == 0) begin
            check("unexpected write", 8'h00, 8'h01);
         end else begin
            e_q = expq.pop_front();
            check("write addr", e_q[15:8], req.addr);
            check("write data", e_q[7:0], req.wdata);
         end
      end
   end
   initial begin
      #400000;
      err_count++;
      summarize();
   end
   initial begin
      resetn = 1'b0;
      strap = 5'h0F;
      tck = 1'b0;
      tdt = 1'b0;
      void'($urandom(13));
      foreach (mem[i]) mem[i] = 8'($urandom);
      idle(5);
      resetn = 1'b1;
      idle(10);
      host_i.start();
      addr(1'b0, 8'h01);
      wptr(8'h60);
      wdat(8'h11, 8'h60);
      wdat(8'h22, 8'h61);
      wdat(8'h08, 8'h62);
      check("pointer", 8'h63, ptr);
      host_i.stop();
      idle(10);
      check("pointer", 8'h00, ptr);
      check("master mode", 8'h01, {7'h0, mm});
      check("scan control", 8'h08, scan);
      host_i.start();
      addr(1'b1, 8'h01);
      rdat(8'h00, 1'b1);
      rdat(8'h01, 1'b1);
      rdat(8'h02, 1'b0);
      host_i.stop();
      host_i.start();
      addr(1'b0, 8'h01);
      wptr(8'h30);
      host_i.start();
      addr(1'b1, 8'h01);
      rdat(8'h30, 1'b1);
      rdat(8'h31, 1'b0);
      host_i.start();
      addr(1'b0, 8'h01);
      wdat(8'h5A, 8'h32);
      host_i.stop();
      strap = 5'h03;
      idle(10);
      host_i.start();
      host_i.wbyte({SLAVE_ADDR_HI_DEF, 5'h03, 1'b0}, a);
      check("foreign ack", 8'h00, {7'h0, a});
      host_i.wbyte(8'h40, a);
      check("ignored ack", 8'h00, {7'h0, a});
      host_i.stop();
      for (int k = 0; k < 3; k++) begin
         p = 8'($urandom_range(0, 8'h5D));
         host_i.start();
         addr(1'b0, 8'h01);
         wptr(p);
         for (int j = 0; j < 3; j++) wdat(8'($urandom), p + 8'(j));
         host_i.stop();
         host_i.start();
         addr(1'b1, 8'h01);
         rdat(8'h00, 1'b0);
         host_i.stop();
      end
      // Clear scan control so only the port control register can enable the tuner bus
      host_i.start();
      addr(1'b0, 8'h01);
      wptr(SCAN_CONTROL_OFS);
      wdat(8'h00, SCAN_CONTROL_OFS);
      host_i.stop();
      tck = 1'b1;
      idle(8);
      check("master mode", 8'h00, {7'h0, mm});
      check("pin0 gpio", 8'h00, {7'h0, g0_oe});
      host_i.start();
      addr(1'b0, 8'h01);
      wptr(GEN_PORT_CONTROL_OFS);
      wdat(8'h10, GEN_PORT_CONTROL_OFS);
      host_i.stop();
      idle(8);
      check("pin0 drive", 8'h01, {7'h0, g0_oe & !g0_o});
      check("clock level", 8'h00, {7'h0, sck_lv});
      tck = 1'b0;
      tdt = 1'b1;
      idle(8);
      check("pin1 drive", 8'h01, {7'h0, g1_oe & !g1_o});
      check("data level", 8'h00, {7'h0, sdt_lv});
      check("clock level", 8'h01, {7'h0, sck_lv});
      tdt = 1'b0;
      idle(10);
      check("pending writes", 8'h00, 8'(expq.size()));
      summarize();
   end
endmodule // tb_top
`default_nettype wire
